/* hdl/rgc_top.sv */
// Contract
// - six ordered stages of lna, mixer, filter gain
// - dwell per stage from divider, reset 0x28
// - strength above drop level lowers gain
// - strength below raise level raises gain
// - policy: free, manual, hold, preamble lock
// - applied gains readable in stage readout
// - loop runs by default after reset
// - 8-bit sar result feeds loop and readback
// - valid packet in packet mode stores postamble strength in result
// - result is two's complement, minus 107 dBm
// - idle command takes filtered strength into result
`default_nettype none

module rgc_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [9:0] mem_addr,
    input wire logic mem_wr_en,
    input wire logic mem_rd_en,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    input wire logic receive_state,
    input wire logic idle_on_state,
    input wire logic packet_mode,
    input wire logic postamble_active,
    input wire logic packet_valid,
    input wire logic preamble_detected,
    input wire logic measure_strength_cmd,
    input wire logic cmp_above,
    output logic [7:0] dac_code,
    output logic [1:0] lna_gain,
    output logic mixer_gain,
    output logic [1:0] filter_gain,
    output logic measure_busy,
    output logic measure_done
);

    typedef enum logic [1:0] {
        RGC_M_IDLE,
        RGC_M_RUN,
        RGC_M_STORE
    } rgc_mstate_t;

    typedef struct packed {
        logic [7:0] setup7;
        logic [7:0] dwell;
        logic [7:0] manual;
        logic [7:0] raise;
        logic [7:0] drop;
        logic [7:0] result;
        logic [7:0] sample;
        logic [7:0] rdata;
        logic [2:0] stage;
        logic preamble_lock;
        logic [7:0] post_value;
        logic [10:0] acc;
        logic [3:0] acc_cnt;
        rgc_mstate_t mstate;
        logic conv_start;
        logic [4:0] readout;
        logic [1:0] lna;
        logic mixer;
        logic [1:0] filter;
        logic mdone;
    } rgc_top_t;

    rgc_top_t s_q, s_d;
    rgc_conv_if conv ();
    logic dwell_tick;
    logic loop_enable;
    rgc_pkg::rgc_policy_t policy;
    logic [7:0] strength;
    logic [15:0] scaled;

    ////////////////////////////////////////////////////////////////////////
    // converter and dwell timer

    rgc_sar u_sar (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .cv(conv.conv),
        .cmp_above(cmp_above),
        .dac_code(dac_code)
    );

    rgc_dwell u_dwell (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .enable(loop_enable),
        .divider(s_q.dwell),
        .tick(dwell_tick)
    );

    assign conv.start = s_q.conv_start;

    ////////////////////////////////////////////////////////////////////////
    // policy decode and loop gating
    // the timer only runs when a step could actually happen, which keeps
    // the first step a full dwell after the loop is released
    always_comb begin
        policy = rgc_pkg::rgc_policy_t'(s_q.setup7[rgc_pkg::POLICY_LSB +: 2]);
        loop_enable = receive_state
            && !s_q.manual[rgc_pkg::MANUAL_HOLD_BIT]
            && (policy == rgc_pkg::RGC_POL_FREE
                || (policy == rgc_pkg::RGC_POL_PREAMBLE && !s_q.preamble_lock));
    end

    ////////////////////////////////////////////////////////////////////////
    // strength in readout units: sample/7 + correction - (109 - 107)
    // the x/7 is a multiply-shift; it never errs by more than one count
    always_comb begin
        scaled = (16'(conv.sample) * rgc_pkg::DIV7_MUL) >> rgc_pkg::DIV7_SHIFT;
        strength = scaled[7:0] + rgc_pkg::STAGE_CORR[s_q.stage]
            - (rgc_pkg::REF_CONV_DB - rgc_pkg::REF_RESULT_DB);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        s_d.conv_start = 1'b0;
        s_d.mdone = 1'b0;

        // host writes; read-only offsets swallow the write
        if (mem_wr_en) begin
            case (mem_addr)
                rgc_pkg::ADDR_SETUP7: begin
                    s_d.setup7 = mem_wdata;
                end
                rgc_pkg::ADDR_DWELL: begin
                    s_d.dwell = mem_wdata;
                end
                rgc_pkg::ADDR_MANUAL: begin
                    s_d.manual = mem_wdata;
                end
                rgc_pkg::ADDR_RAISE: begin
                    s_d.raise = mem_wdata;
                end
                rgc_pkg::ADDR_DROP: begin
                    s_d.drop = mem_wdata;
                end
                default: begin
                end
            endcase
        end

        // read data registered, one cycle after the strobe
        if (mem_rd_en) begin
            case (mem_addr)
                rgc_pkg::ADDR_SETUP7: s_d.rdata = s_q.setup7;
                rgc_pkg::ADDR_RESULT: s_d.rdata = s_q.result;
                rgc_pkg::ADDR_CONV_LO: s_d.rdata = s_q.sample;
                rgc_pkg::ADDR_CONV_HI: s_d.rdata = 8'h00;
                rgc_pkg::ADDR_DWELL: s_d.rdata = s_q.dwell;
                rgc_pkg::ADDR_MANUAL: s_d.rdata = s_q.manual;
                rgc_pkg::ADDR_RAISE: s_d.rdata = s_q.raise;
                rgc_pkg::ADDR_DROP: s_d.rdata = s_q.drop;
                rgc_pkg::ADDR_READOUT: s_d.rdata = {3'h0, s_q.readout};
                default: s_d.rdata = 8'h00;
            endcase
        end

        // keep the converter busy while receiving or measuring
        if (!conv.busy && !s_q.conv_start && (receive_state || s_q.mstate == RGC_M_RUN)) begin
            s_d.conv_start = 1'b1;
        end
        if (conv.done) begin
            s_d.sample = conv.sample;
        end

        // preamble lock lives for one receive visit
        if (!receive_state) begin
            s_d.preamble_lock = 1'b0;
        end else if (preamble_detected && policy == rgc_pkg::RGC_POL_PREAMBLE) begin
            s_d.preamble_lock = 1'b1;
        end

        // one step per dwell tick, decided on the latest sample
        if (dwell_tick && loop_enable) begin
            if (s_q.sample > s_q.drop) begin
                if (s_q.stage != rgc_pkg::LAST_STAGE) begin
                    s_d.stage = s_q.stage + 3'h1;
                end
            end else if (s_q.sample < s_q.raise) begin
                if (s_q.stage != 3'h0) begin
                    s_d.stage = s_q.stage - 3'h1;
                end
            end
        end

        // applied gains: manual fields or the stage table
        if (policy == rgc_pkg::RGC_POL_MANUAL) begin
            s_d.lna = s_q.manual[rgc_pkg::MANUAL_LNA_LSB +: 2];
            s_d.mixer = s_q.manual[rgc_pkg::MANUAL_MIXER_BIT];
            s_d.filter = s_q.manual[rgc_pkg::MANUAL_FILTER_LSB +: 2];
            s_d.readout = s_q.manual[4:0];
        end else begin
            s_d.lna = rgc_pkg::STAGE_LNA[s_d.stage];
            s_d.mixer = rgc_pkg::STAGE_MIXER[s_d.stage];
            s_d.filter = rgc_pkg::STAGE_FILTER[s_d.stage];
            s_d.readout = rgc_pkg::STAGE_CODE[s_d.stage];
        end

        // last strength seen during the postamble is kept for the packet end
        if (postamble_active && conv.done) begin
            s_d.post_value = strength;
        end
        if (packet_valid && packet_mode) begin
            s_d.result = s_q.post_value;
        end

        // on-demand measurement: average eight samples from idle
        case (s_q.mstate)
            RGC_M_IDLE: begin
                if (measure_strength_cmd && idle_on_state) begin
                    s_d.mstate = RGC_M_RUN;
                    s_d.acc = '0;
                    s_d.acc_cnt = '0;
                end
            end
            RGC_M_RUN: begin
                if (conv.done) begin
                    s_d.acc = s_q.acc + 11'(strength);
                    s_d.acc_cnt = s_q.acc_cnt + 4'h1;
                    if (s_q.acc_cnt + 4'h1 == rgc_pkg::FILTER_COUNT) begin
                        s_d.mstate = RGC_M_STORE;
                    end
                end
            end
            RGC_M_STORE: begin
                s_d.result = 8'(s_q.acc >> rgc_pkg::FILTER_LOG2);
                s_d.mdone = 1'b1;
                s_d.mstate = RGC_M_IDLE;
            end
            default: begin
                s_d.mstate = RGC_M_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; reset leaves the loop free running at full gain
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.setup7 <= rgc_pkg::RST_SETUP7;
            s_q.dwell <= rgc_pkg::RST_DWELL;
            s_q.manual <= rgc_pkg::RST_MANUAL;
            s_q.raise <= rgc_pkg::RST_RAISE;
            s_q.drop <= rgc_pkg::RST_DROP;
            s_q.mstate <= RGC_M_IDLE;
            s_q.lna <= rgc_pkg::LVL_HIGH;
            s_q.mixer <= 1'b1;
            s_q.filter <= rgc_pkg::LVL_HIGH;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign mem_rdata = s_q.rdata;
    assign lna_gain = s_q.lna;
    assign mixer_gain = s_q.mixer;
    assign filter_gain = s_q.filter;
    assign measure_busy = (s_q.mstate != RGC_M_IDLE);
    assign measure_done = s_q.mdone;

endmodule

`default_nettype wire

/* hdl/rgc_pkg.sv */
`default_nettype none

package rgc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // configuration memory offsets
    localparam logic [9:0] ADDR_SETUP7 = 10'h113;
    localparam logic [9:0] ADDR_RESULT = 10'h312;
    localparam logic [9:0] ADDR_CONV_LO = 10'h327;
    localparam logic [9:0] ADDR_CONV_HI = 10'h328;
    localparam logic [9:0] ADDR_DWELL = 10'h32f;
    localparam logic [9:0] ADDR_MANUAL = 10'h35d;
    localparam logic [9:0] ADDR_RAISE = 10'h35e;
    localparam logic [9:0] ADDR_DROP = 10'h35f;
    localparam logic [9:0] ADDR_READOUT = 10'h360;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int POLICY_LSB = 6;         // gain_loop_policy in radio_setup_seven[7:6]
    localparam int MANUAL_HOLD_BIT = 6;    // 0x40 in gain_manual_control holds the loop
    localparam int MANUAL_LNA_LSB = 0;     // [1:0] lna level
    localparam int MANUAL_MIXER_BIT = 2;   // [2] mixer level
    localparam int MANUAL_FILTER_LSB = 3;  // [4:3] filter level

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_SETUP7 = 8'h00;
    localparam logic [7:0] RST_DWELL = 8'h28;
    localparam logic [7:0] RST_MANUAL = 8'h00;
    localparam logic [7:0] RST_RAISE = 8'h30;
    localparam logic [7:0] RST_DROP = 8'h60;

    ////////////////////////////////////////////////////////////////////////
    // timing: one divider unit is 62 cycles of 10 ns (620 ns), so 0x28 units give 24.8 us
    localparam int CLK_MHZ = 100;
    localparam int DWELL_UNIT_NS = 625;
    localparam logic [6:0] DWELL_UNIT_CYC = 7'((DWELL_UNIT_NS * CLK_MHZ) / 1000);

    ////////////////////////////////////////////////////////////////////////
    // strength arithmetic: x/7 ~ (x*73)>>9
    localparam logic [15:0] DIV7_MUL = 16'h0049;
    localparam int DIV7_SHIFT = 9;
    localparam logic [7:0] REF_RESULT_DB = 8'h6b;  // 107
    localparam logic [7:0] REF_CONV_DB = 8'h6d;    // 109
    localparam int FILTER_LOG2 = 3;                // eight samples averaged
    localparam logic [3:0] FILTER_COUNT = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // six gain stages, index 0 is stage 1 (highest gain)
    localparam logic [2:0] LAST_STAGE = 3'h5;
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MED = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] STAGE_LNA [0:5] = '{LVL_HIGH, LVL_HIGH, LVL_MED, LVL_LOW, LVL_LOW, LVL_LOW};
    localparam logic STAGE_MIXER [0:5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    localparam logic [1:0] STAGE_FILTER [0:5] = '{LVL_HIGH, LVL_HIGH, LVL_HIGH, LVL_HIGH, LVL_MED, LVL_LOW};
    localparam logic [4:0] STAGE_CODE [0:5] = '{5'h00, 5'h01, 5'h02, 5'h0a, 5'h12, 5'h16};
    localparam logic [7:0] STAGE_CORR [0:5] = '{8'h2c, 8'h23, 8'h1a, 8'h11, 8'h0a, 8'h00};

    typedef enum logic [1:0] {
        RGC_POL_FREE,
        RGC_POL_MANUAL,
        RGC_POL_HOLD,
        RGC_POL_PREAMBLE
    } rgc_policy_t;

endpackage

`default_nettype wire

/* hdl/rgc_conv_if.sv */
`default_nettype none

// converter request and result between the controller and the sar engine
interface rgc_conv_if;
    logic start;
    logic busy;
    logic done;
    logic [7:0] sample;

    modport ctrl (output start, input busy, input done, input sample);
    modport conv (input start, output busy, output done, output sample);
endinterface

`default_nettype wire

/* hdl/rgc_sar.sv */
`default_nettype none

// 8-bit successive approximation against the log-amp level, one bit a cycle
module rgc_sar (
    input wire logic ref_clk,
    input wire logic arst_n,
    rgc_conv_if.conv cv,
    input wire logic cmp_above,
    output logic [7:0] dac_code
);

    typedef struct packed {
        logic busy;
        logic done;
        logic [2:0] bitpos;
        logic [7:0] code;
        logic [7:0] result;
    } rgc_sar_t;

    rgc_sar_t s_q, s_d;

    ////////////////////////////////////////////////////////////////////////
    // trial bit kept only when the level sits at or above the trial code
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (s_q.busy) begin
            if (!cmp_above) begin
                s_d.code[s_q.bitpos] = 1'b0;
            end
            if (s_q.bitpos == 3'h0) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.result = s_d.code;
            end else begin
                s_d.bitpos = s_q.bitpos - 3'h1;
                s_d.code[s_q.bitpos - 3'h1] = 1'b1;
            end
        end else if (cv.start) begin
            s_d.busy = 1'b1;
            s_d.bitpos = 3'h7;
            s_d.code = 8'h80;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cv.busy = s_q.busy;
    assign cv.done = s_q.done;
    assign cv.sample = s_q.result;
    assign dac_code = s_q.code;

endmodule

`default_nettype wire

/* hdl/rgc_dwell.sv */
`default_nettype none

// dwell timer: divider units of a fixed prescale, one tick per period
module rgc_dwell (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic [7:0] divider,
    output logic tick
);

    typedef struct packed {
        logic [6:0] pre;
        logic [7:0] units;
        logic tick;
    } rgc_dwell_t;

    rgc_dwell_t s_q, s_d;

    ////////////////////////////////////////////////////////////////////////
    // a zero divider behaves as one so the loop never stalls for good
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!enable) begin
            s_d.pre = '0;
            s_d.units = '0;
        end else if (s_q.pre >= rgc_pkg::DWELL_UNIT_CYC - 7'h1) begin
            s_d.pre = '0;
            if (s_q.units + 8'h1 >= divider) begin
                s_d.units = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.units = s_q.units + 8'h1;
            end
        end else begin
            s_d.pre = s_q.pre + 7'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

`default_nettype wire

/* verification/rgc_top_asserts.sv */
`default_nettype none

module rgc_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [9:0] mem_addr,
    input wire logic mem_wr_en,
    input wire logic mem_rd_en,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic idle_on_state,
    input wire logic measure_strength_cmd,
    input wire logic cmp_above,
    input wire logic [7:0] dac_code,
    input wire logic [1:0] lna_gain,
    input wire logic mixer_gain,
    input wire logic [1:0] filter_gain,
    input wire logic measure_busy,
    input wire logic measure_done
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    logic [1:0] pol_q, mgap_q, fz_q, mc_q;
    logic [7:0] man_q, gap_q;
    logic [4:0] g, g_q, rexp;
    logic [2:0] idx, idx_q;
    logic wcfg, auto_ok;

    // policy/manual shadows and settle counters
    assign g = {lna_gain, mixer_gain, filter_gain};
    assign wcfg = mem_wr_en && (mem_addr == rgc_pkg::ADDR_SETUP7 || mem_addr == rgc_pkg::ADDR_MANUAL);
    assign auto_ok = (mgap_q == 2'h3);
    assign rexp = (pol_q == 2'h1) ? man_q[4:0] : rgc_pkg::STAGE_CODE[idx];

    // stage index from applied gains
    always_comb begin
        case (g)
            5'h16: idx = 3'h0;
            5'h12: idx = 3'h1;
            5'h0a: idx = 3'h2;
            5'h02: idx = 3'h3;
            5'h01: idx = 3'h4;
            default: idx = 3'h5;
        endcase
    end

    // helper counters, saturating
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pol_q <= 2'h0;
            man_q <= 8'h00;
            g_q <= 5'h16;
            idx_q <= 3'h0;
            gap_q <= 8'hff;
            mgap_q <= 2'h0;
            fz_q <= 2'h0;
            mc_q <= 2'h0;
        end else begin
            if (mem_wr_en && mem_addr == rgc_pkg::ADDR_SETUP7) pol_q <= mem_wdata[7:6];
            if (mem_wr_en && mem_addr == rgc_pkg::ADDR_MANUAL) man_q <= mem_wdata;
            g_q <= g;
            idx_q <= idx;
            gap_q <= (g != g_q) ? 8'h00 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
            mgap_q <= (pol_q == 2'h1) ? 2'h0 : ((mgap_q == 2'h3) ? mgap_q : mgap_q + 2'h1);
            fz_q <= (pol_q == 2'h2 || (pol_q == 2'h0 && man_q[6])) ? ((fz_q == 2'h3) ? fz_q : fz_q + 2'h1) : 2'h0;
            mc_q <= (pol_q == 2'h1 && !wcfg) ? ((mc_q == 2'h3) ? mc_q : mc_q + 2'h1) : 2'h0;
        end
    end

    sequence s_sar_first;
        dac_code == 8'h80;
    endsequence
    sequence s_cmd;
        measure_strength_cmd && idle_on_state && !measure_busy;
    endsequence
    sequence s_run;
        measure_busy ##[60:120] measure_done;
    endsequence

    property p_sar_msb;
        s_sar_first |=> dac_code == {$past(cmp_above), 7'h40};
    endproperty
    a_sar_msb: assert property (p_sar_msb) else $error("sar first trial wrong");

    property p_stage_legal;
        auto_ok |-> g inside {5'h16, 5'h12, 5'h0a, 5'h02, 5'h01, 5'h00};
    endproperty
    a_stage_legal: assert property (p_stage_legal) else $error("gain set not a stage");

    property p_dwell_gap;
        auto_ok && g != g_q |-> gap_q >= 8'd61;
    endproperty
    a_dwell_gap: assert property (p_dwell_gap) else $error("stage change too soon");

    property p_one_step;
        auto_ok && g != g_q |-> (idx == idx_q + 3'h1) || (idx_q == idx + 3'h1);
    endproperty
    a_one_step: assert property (p_one_step) else $error("stage jumped");

    property p_frozen;
        fz_q == 2'h3 |-> g == g_q;
    endproperty
    a_frozen: assert property (p_frozen) else $error("gain moved while held");

    property p_manual;
        mc_q[1] |-> lna_gain == man_q[1:0] && mixer_gain == man_q[2] && filter_gain == man_q[4:3];
    endproperty
    a_manual: assert property (p_manual) else $error("manual gains not applied");

    property p_readout;
        mem_rd_en && mem_addr == rgc_pkg::ADDR_READOUT && (mc_q[1] || auto_ok) |=> mem_rdata == {3'h0, $past(rexp)};
    endproperty
    a_readout: assert property (p_readout) else $error("stage readout wrong");

    property p_meas;
        s_cmd |=> s_run;
    endproperty
    a_meas: assert property (p_meas) else $error("measurement did not complete");

    property p_refuse;
        measure_strength_cmd && !idle_on_state && !measure_busy |=> !measure_busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("command taken outside idle");

    property p_done;
        measure_done |-> !measure_busy ##1 !measure_done;
    endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
endmodule

bind rgc_top rgc_checker rgc_checker_i (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .mem_addr(mem_addr),
    .mem_wr_en(mem_wr_en),
    .mem_rd_en(mem_rd_en),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .idle_on_state(idle_on_state),
    .measure_strength_cmd(measure_strength_cmd),
    .cmp_above(cmp_above),
    .dac_code(dac_code),
    .lna_gain(lna_gain),
    .mixer_gain(mixer_gain),
    .filter_gain(filter_gain),
    .measure_busy(measure_busy),
    .measure_done(measure_done)
);

`default_nettype wire

/* verification/rgc_host_model.sv */
`default_nettype none

module rgc_host_model (
    input wire logic ref_clk,
    output logic [9:0] mem_addr,
    output logic mem_wr_en,
    output logic mem_rd_en,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // idle bus; released lines inverted
    initial begin
        mem_addr = 10'h3ff;
        mem_wr_en = 1'b0;
        mem_rd_en = 1'b0;
        mem_wdata = 8'h00;
    end

    // one-cycle write strobe
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        mem_addr = a;
        mem_wdata = d;
        mem_wr_en = 1'b1;
        @(posedge ref_clk);
        #1;
        mem_wr_en = 1'b0;
        mem_addr = ~a;
        mem_wdata = ~d;
    endtask

    // data taken after the strobe edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        mem_addr = a;
        mem_rd_en = 1'b1;
        @(posedge ref_clk);
        #1;
        mem_rd_en = 1'b0;
        mem_addr = ~a;
        d = mem_rdata;
    endtask

    // manual gain word
    function automatic logic [7:0] gain_word(input logic [1:0] lna, input logic mix, input logic [1:0] filt);
        return {3'h0, filt, mix, lna};
    endfunction

    // host power estimate; hold skipped if locked
    task automatic strength(input logic locked, output logic [7:0] dbm, output logic [7:0] smp);
        logic [7:0] st;
        logic [7:0] corr;
        if (!locked) wr(rgc_pkg::ADDR_MANUAL, 8'h40);
        rd(rgc_pkg::ADDR_READOUT, st);
        rd(rgc_pkg::ADDR_CONV_LO, smp);
        if (!locked) wr(rgc_pkg::ADDR_MANUAL, 8'h00);
        case (st)
            8'h00: corr = 8'h2c;
            8'h01: corr = 8'h23;
            8'h02: corr = 8'h1a;
            8'h0a: corr = 8'h11;
            8'h12: corr = 8'h0a;
            default: corr = 8'h00;
        endcase
        dbm = smp / 8'h07 + corr - 8'h6d;
    endtask
endmodule

`default_nettype wire

/* verification/tb.sv */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic arst_n;
    logic [9:0] mem_addr;
    logic mem_wr_en, mem_rd_en;
    logic [7:0] mem_wdata, mem_rdata, dac_code, level, d1, s, r;
    logic receive_state, idle_on_state, packet_mode, postamble_active, packet_valid;
    logic preamble_detected, measure_strength_cmd, cmp_above, mixer_gain, measure_busy, measure_done;
    logic [1:0] lna_gain, filter_gain;
    logic [9:0] ra [5] = '{10'h113, 10'h32f, 10'h35d, 10'h35e, 10'h35f};
    logic [7:0] rv [5] = '{8'h00, 8'h28, 8'h00, 8'h30, 8'h60};
    int fails = 0, comparisons = 0, i;

    always #5 ref_clk = ~ref_clk;
    // comparator against the log level
    assign cmp_above = (level >= dac_code);

    rgc_top rgc_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .mem_addr(mem_addr), .mem_wr_en(mem_wr_en),
        .mem_rd_en(mem_rd_en), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .receive_state(receive_state),
        .idle_on_state(idle_on_state), .packet_mode(packet_mode), .postamble_active(postamble_active),
        .packet_valid(packet_valid), .preamble_detected(preamble_detected),
        .measure_strength_cmd(measure_strength_cmd), .cmp_above(cmp_above), .dac_code(dac_code),
        .lna_gain(lna_gain), .mixer_gain(mixer_gain), .filter_gain(filter_gain),
        .measure_busy(measure_busy), .measure_done(measure_done));

    rgc_host_model rgc_host_model_i (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wr_en(mem_wr_en),
        .mem_rd_en(mem_rd_en), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic summarize;
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // inputs change 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [7:0] exp_v);
        logic [7:0] d;
        rgc_host_model_i.rd(a, d);
        chk(d, exp_v);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        {receive_state, idle_on_state, packet_mode, postamble_active, packet_valid} = 5'h00;
        {preamble_detected, measure_strength_cmd} = 2'h0;
        level = 8'h9c;
        cyc(2);
        arst_n = 1'b1;
        foreach (ra[k]) rdchk(ra[k], rv[k]);
        rdchk(10'h200, 8'h00);
        // default loop, full dwell, strong level
        receive_state = 1'b1;
        cyc(2470);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h00);
        cyc(30);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h01);
        rgc_host_model_i.wr(rgc_pkg::ADDR_DWELL, 8'h01);
        rdchk(rgc_pkg::ADDR_DWELL, 8'h01);
        receive_state = 1'b0;
        cyc(2);
        receive_state = 1'b1;
        cyc(400);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h16);
        chk({3'h0, lna_gain, mixer_gain, filter_gain}, 8'h00);
        level = 8'h10;
        cyc(400);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h00);
        chk({3'h0, lna_gain, mixer_gain, filter_gain}, 8'h16);
        // hold, manual, preamble lock
        level = 8'h9c;
        rgc_host_model_i.wr(rgc_pkg::ADDR_SETUP7, 8'h80);
        cyc(200);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h00);
        rgc_host_model_i.wr(rgc_pkg::ADDR_SETUP7, 8'h40);
        rgc_host_model_i.wr(rgc_pkg::ADDR_MANUAL, rgc_host_model_i.gain_word(2'h1, 1'b0, 2'h1));
        cyc(3);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h09);
        chk({3'h0, lna_gain, mixer_gain, filter_gain}, 8'h09);
        rgc_host_model_i.wr(rgc_pkg::ADDR_SETUP7, 8'hc0);
        preamble_detected = 1'b1;
        cyc(1);
        preamble_detected = 1'b0;
        cyc(200);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h00);
        receive_state = 1'b0;
        cyc(2);
        receive_state = 1'b1;
        cyc(700);
        rdchk(rgc_pkg::ADDR_READOUT, 8'h16);
        // host estimate, postamble capture
        level = 8'h50;
        rgc_host_model_i.wr(rgc_pkg::ADDR_SETUP7, 8'h00);
        cyc(30);
        rgc_host_model_i.strength(1'b0, d1, s);
        chk(s, 8'h50);
        chk(d1, 8'h0b - 8'h6d);
        rgc_host_model_i.wr(rgc_pkg::ADDR_SETUP7, 8'h80);
        packet_mode = 1'b1;
        postamble_active = 1'b1;
        cyc(40);
        packet_valid = 1'b1;
        cyc(1);
        packet_valid = 1'b0;
        postamble_active = 1'b0;
        rgc_host_model_i.rd(rgc_pkg::ADDR_RESULT, r);
        chk(r - 8'h6b, d1);
        // command refused outside idle, taken in idle
        receive_state = 1'b0;
        measure_strength_cmd = 1'b1;
        cyc(1);
        measure_strength_cmd = 1'b0;
        cyc(2);
        chk({7'h00, measure_busy}, 8'h00);
        idle_on_state = 1'b1;
        measure_strength_cmd = 1'b1;
        cyc(1);
        measure_strength_cmd = 1'b0;
        for (i = 0; i < 300 && measure_done !== 1'b1; i++) cyc(1);
        if (i == 300) fails++;
        else rdchk(rgc_pkg::ADDR_RESULT, r);
        summarize();
    end
endmodule

`default_nettype wire
